// File: shared/upac_defines.svh
// Constants of the USB port attach and mode controller: timing counts
// and select-code layout. Assumes a 10 MHz core clock.
// Operation
// - Bypass and main switch never both on
// - Detect state keeps data switch open
// - Attach check only in Detect, bypass only path
// - Load above threshold long enough flags attach
// - After attach, enable plus supply closes main switch
// - Removal check only while detect feature enabled
// - Load below threshold long enough flags removal
// - Removal: open switches, flag, discharge, back to Detect
// - Codes 010 and 110 select pass-through
// - 100 SDP, 101 emulation cycle, 111 CDP
// - Pass-through: data switch closed, trip limit, no discharge
// - SDP: discharge first, then data switch, trip limit
// - Changing among SDP, DCP, CDP cycles VBUS
// - CDP: discharge, data switch closed, CDP profile
// - CDP always constant current, profile kept on failure
// - CDP data-plus primary level answered on data-minus
// - Data-plus low returns data-minus low within 20 ms
// - Secondary detection on data-minus needs no action
// - Standalone DCP: discharge, profile, timeout disabled
// - Charging under DCP keeps short, data switch open
// - DCP short resistor stays through detection steps
`ifndef UPAC_DEFINES_SVH
`define UPAC_DEFINES_SVH

`define UPAC_CLK_HZ 10000000
// Qualification and discharge times in microseconds (plain defaults)
`define UPAC_ATTACH_QUAL_US 10000
`define UPAC_REMOVAL_QUAL_US 10000
`define UPAC_DISCHARGE_US 20000
`define UPAC_CDP_RESP_MS 20
// Cycle counts: each time times whole cycles per unit, no rounding up
`define UPAC_ATTACH_QUAL_CYC (`UPAC_CNT_W'(`UPAC_ATTACH_QUAL_US * (`UPAC_CLK_HZ / 1000000)))
`define UPAC_REMOVAL_QUAL_CYC (`UPAC_CNT_W'(`UPAC_REMOVAL_QUAL_US * (`UPAC_CLK_HZ / 1000000)))
`define UPAC_DISCHARGE_CYC (`UPAC_CNT_W'(`UPAC_DISCHARGE_US * (`UPAC_CLK_HZ / 1000000)))
`define UPAC_CDP_RESP_CYC (`UPAC_CNT_W'(`UPAC_CDP_RESP_MS * (`UPAC_CLK_HZ / 1000)))
// Select code bit order {high, mid, emulation}
`define UPAC_SEL_PASS_A 3'h2
`define UPAC_SEL_PASS_B 3'h6
`define UPAC_SEL_DCE_A 3'h1
`define UPAC_SEL_DCP 3'h3
`define UPAC_SEL_SDP 3'h4
`define UPAC_SEL_DCE_B 3'h5
`define UPAC_SEL_CDP 3'h7
`define UPAC_CNT_W 24

`endif

// File: shared/upac_pkg.sv
// Types of the USB port attach and mode controller.
// Assumes upac_defines.svh for numeric constants.
package upac_pkg;

  typedef enum logic [5:0] {
    UPAC_ST_DETECT = 6'h01,
    UPAC_ST_ATTACHED = 6'h02,
    UPAC_ST_DISCHARGE = 6'h04,
    UPAC_ST_ACTIVE = 6'h08,
    UPAC_ST_REMOVED = 6'h10,
    UPAC_ST_IDLE = 6'h20
  } upac_state_t;

  typedef enum logic [2:0] {
    UPAC_MODE_PASS = 3'h0,
    UPAC_MODE_SDP = 3'h1,
    UPAC_MODE_DCP = 3'h2,
    UPAC_MODE_CDP = 3'h3,
    UPAC_MODE_DCE = 3'h4
  } upac_mode_t;

  // Mode select controls
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_mid;
    logic emulation_select;
  } upac_sel_t;

  // Analog comparator results from the port
  typedef struct packed {
    logic load_above_attach;
    logic load_below_removal;
    logic main_supply_ok;
    logic vbus_discharged;
    logic dp_primary_level;
    logic dp_high;
  } upac_sense_t;

  // Switch and profile controls toward the analog section
  typedef struct packed {
    logic main_switch_on;
    logic bypass_switch_on;
    logic discharge_on;
    logic hs_switch_closed;
    logic cc_limit;
    logic cdp_profile;
    logic dcp_short;
    logic dm_drive_0p6;
    logic em_timeout_en;
  } upac_ctrl_t;

endpackage

// File: hdl/upac_qual_timer.sv
// Qualification timer: reports when a condition has held for longer
// than a set number of cycles. Assumes synchronous inputs.
`timescale 1ns/10ps
`include "upac_defines.svh"
module upac_qual_timer #(
  parameter logic [`UPAC_CNT_W-1:0] LIMIT = 24'h000001
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic cond,
  output logic qualified
);

  logic [`UPAC_CNT_W-1:0] cnt_r;
  logic [`UPAC_CNT_W-1:0] cnt_nxt;
  logic qual_r;
  logic qual_nxt;

  // Count while the condition holds, restart when it drops
  always_comb begin
    cnt_nxt = '0;
    qual_nxt = 1'b0;
    if (enable && cond) begin
      if (cnt_r > LIMIT) begin
        cnt_nxt = cnt_r;
        qual_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 24'h000001;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      qual_r <= qual_nxt;
    end
  end

  assign qualified = qual_r;

endmodule

// File: hdl/upac_port_ctrl.sv
// Attach/removal qualification and active mode control of a USB port
// power controller. Inputs are synchronous to clk; analog levels
// arrive as comparator bits, switch controls leave as registered bits.
`timescale 1ns/10ps
`include "upac_defines.svh"
module upac_port_ctrl #(
  parameter logic [`UPAC_CNT_W-1:0] ATTACH_QUAL_CYC = `UPAC_ATTACH_QUAL_CYC,
  parameter logic [`UPAC_CNT_W-1:0] REMOVAL_QUAL_CYC = `UPAC_REMOVAL_QUAL_CYC,
  parameter logic [`UPAC_CNT_W-1:0] DISCHARGE_CYC = `UPAC_DISCHARGE_CYC,
  parameter logic [`UPAC_CNT_W-1:0] CDP_RESP_CYC = `UPAC_CDP_RESP_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic port_power_enable,
  input wire logic detect_feature_enable,
  input wire upac_pkg::upac_sel_t sel,
  input wire upac_pkg::upac_sense_t sense,
  input wire logic status_clear,
  output upac_pkg::upac_ctrl_t ctrl,
  output logic attach_flag_n,
  output logic attach_pin_status,
  output logic attach_status,
  output logic removal_status,
  output upac_pkg::upac_mode_t active_mode,
  output logic in_detect
);

  // Decode select controls into an active mode
  function automatic upac_pkg::upac_mode_t decode_mode(input upac_pkg::upac_sel_t s);
    case (s)
      `UPAC_SEL_PASS_A, `UPAC_SEL_PASS_B: decode_mode = upac_pkg::UPAC_MODE_PASS;
      `UPAC_SEL_SDP: decode_mode = upac_pkg::UPAC_MODE_SDP;
      `UPAC_SEL_CDP: decode_mode = upac_pkg::UPAC_MODE_CDP;
      `UPAC_SEL_DCP: decode_mode = upac_pkg::UPAC_MODE_DCP;
      default: decode_mode = upac_pkg::UPAC_MODE_DCE;
    endcase
  endfunction

  // Modes whose entry requires a VBUS discharge
  function automatic logic needs_discharge(input upac_pkg::upac_mode_t m);
    needs_discharge = (m != upac_pkg::UPAC_MODE_PASS);
  endfunction

  upac_pkg::upac_state_t state_r, state_nxt;
  upac_pkg::upac_mode_t mode_r, mode_nxt;
  upac_pkg::upac_ctrl_t ctrl_r, ctrl_nxt;
  logic attach_n_r, attach_n_nxt;
  logic apin_r, apin_nxt;
  logic att_r, att_nxt;
  logic rem_r, rem_nxt;
  logic [`UPAC_CNT_W-1:0] dis_cnt_r, dis_cnt_nxt;
  logic [`UPAC_CNT_W-1:0] cdp_cnt_r, cdp_cnt_nxt;
  logic cdp_wait_up_r, cdp_wait_up_nxt;
  logic cdp_wait_dn_r, cdp_wait_dn_nxt;
  logic in_detect_r, in_detect_nxt;
  logic attach_qualified;
  logic removal_qualified;
  logic removal_enable;
  upac_pkg::upac_mode_t sel_mode;

  assign sel_mode = decode_mode(sel);
  // Removal watch in Active and in the Detect power state after an attach
  // (Attached, Idle), gated by the feature bit; before an attach there is
  // no load, so a watch there would flag removals of nothing over and over
  assign removal_enable = detect_feature_enable &&
    ((state_r == upac_pkg::UPAC_ST_ATTACHED) || (state_r == upac_pkg::UPAC_ST_IDLE) ||
    (state_r == upac_pkg::UPAC_ST_ACTIVE));

  // Attach qualification only while in Detect on the bypass supply
  upac_qual_timer #(.LIMIT(ATTACH_QUAL_CYC)) u_attach_qual (
    .clk(clk),
    .rstn(rstn),
    .enable(state_r == upac_pkg::UPAC_ST_DETECT),
    .cond(sense.load_above_attach),
    .qualified(attach_qualified)
  );

  // Removal qualification on low load current
  upac_qual_timer #(.LIMIT(REMOVAL_QUAL_CYC)) u_removal_qual (
    .clk(clk),
    .rstn(rstn),
    .enable(removal_enable),
    .cond(sense.load_below_removal),
    .qualified(removal_qualified)
  );

  // Main state machine and switch controls
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    attach_n_nxt = attach_n_r;
    apin_nxt = apin_r;
    att_nxt = att_r;
    rem_nxt = rem_r;
    dis_cnt_nxt = dis_cnt_r;
    cdp_cnt_nxt = cdp_cnt_r;
    cdp_wait_up_nxt = cdp_wait_up_r;
    cdp_wait_dn_nxt = cdp_wait_dn_r;
    if (status_clear) begin
      apin_nxt = 1'b0;
      att_nxt = 1'b0;
      rem_nxt = 1'b0;
    end
    unique case (state_r)
      upac_pkg::UPAC_ST_DETECT: begin
        // Bypass supply only, data switch open, no profile
        ctrl_nxt = '0;
        ctrl_nxt.bypass_switch_on = 1'b1;
        ctrl_nxt.hs_switch_closed = 1'b0;
        if (attach_qualified) begin
          attach_n_nxt = 1'b0;
          apin_nxt = 1'b1;
          att_nxt = 1'b1;
          state_nxt = upac_pkg::UPAC_ST_ATTACHED;
        end
      end
      upac_pkg::UPAC_ST_ATTACHED: begin
        // Bypass stays the only path until power is allowed
        ctrl_nxt = '0;
        ctrl_nxt.bypass_switch_on = 1'b1;
        if (removal_qualified) begin
          // Device left before power came: open both paths, then discharge
          ctrl_nxt = '0;
          dis_cnt_nxt = '0;
          state_nxt = upac_pkg::UPAC_ST_REMOVED;
        end else if (port_power_enable && sense.main_supply_ok) begin
          ctrl_nxt.bypass_switch_on = 1'b0;
          mode_nxt = sel_mode;
          if (needs_discharge(sel_mode)) begin
            ctrl_nxt.discharge_on = 1'b1;
            dis_cnt_nxt = '0;
            state_nxt = upac_pkg::UPAC_ST_DISCHARGE;
          end else begin
            state_nxt = upac_pkg::UPAC_ST_ACTIVE;
          end
        end
      end
      upac_pkg::UPAC_ST_DISCHARGE: begin
        // Cycle VBUS before a BC1.2 role is presented
        ctrl_nxt = '0;
        ctrl_nxt.discharge_on = 1'b1;
        dis_cnt_nxt = dis_cnt_r + 24'h000001;
        if (dis_cnt_r >= DISCHARGE_CYC) begin
          state_nxt = upac_pkg::UPAC_ST_ACTIVE;
          cdp_wait_up_nxt = 1'b1;
          cdp_wait_dn_nxt = 1'b0;
          cdp_cnt_nxt = '0;
        end
      end
      upac_pkg::UPAC_ST_ACTIVE: begin
        ctrl_nxt = '0;
        ctrl_nxt.main_switch_on = 1'b1;
        ctrl_nxt.bypass_switch_on = 1'b0;
        unique case (mode_r)
          upac_pkg::UPAC_MODE_PASS, upac_pkg::UPAC_MODE_SDP: begin
            ctrl_nxt.hs_switch_closed = 1'b1;
            ctrl_nxt.cc_limit = 1'b0;
          end
          upac_pkg::UPAC_MODE_CDP: begin
            ctrl_nxt.hs_switch_closed = 1'b1;
            ctrl_nxt.cc_limit = 1'b1;
            ctrl_nxt.cdp_profile = 1'b1;
            // Primary detection answer, then release on data-plus low
            if (cdp_wait_up_r && sense.dp_primary_level) begin
              ctrl_nxt.dm_drive_0p6 = 1'b1;
              cdp_wait_up_nxt = 1'b0;
              cdp_wait_dn_nxt = 1'b1;
            end else if (cdp_wait_dn_r) begin
              ctrl_nxt.dm_drive_0p6 = sense.dp_high;
              if (!sense.dp_high) begin
                cdp_wait_dn_nxt = 1'b0;
              end
            end
            cdp_cnt_nxt = '0;
          end
          upac_pkg::UPAC_MODE_DCP: begin
            ctrl_nxt.dcp_short = 1'b1;
            ctrl_nxt.hs_switch_closed = 1'b0;
            ctrl_nxt.cc_limit = 1'b1;
            ctrl_nxt.em_timeout_en = 1'b0;
          end
          upac_pkg::UPAC_MODE_DCE: begin
            // Cycle sequencing lives elsewhere; DCP inside it times out
            ctrl_nxt.dcp_short = 1'b1;
            ctrl_nxt.cc_limit = 1'b1;
            ctrl_nxt.em_timeout_en = 1'b1;
          end
          default: begin
            ctrl_nxt.hs_switch_closed = 1'b0;
          end
        endcase
        if (removal_qualified) begin
          ctrl_nxt = '0;
          // Fresh count, else a count left by a mode change ends the discharge at once
          dis_cnt_nxt = '0;
          state_nxt = upac_pkg::UPAC_ST_REMOVED;
        end else if (sel_mode != mode_r) begin
          // Changes to pass-through take effect at once, without a discharge
          mode_nxt = sel_mode;
          if (needs_discharge(sel_mode)) begin
            ctrl_nxt = '0;
            ctrl_nxt.discharge_on = 1'b1;
            dis_cnt_nxt = '0;
            state_nxt = upac_pkg::UPAC_ST_DISCHARGE;
          end
        end else if (!port_power_enable && (mode_r != upac_pkg::UPAC_MODE_PASS)) begin
          ctrl_nxt = '0;
          state_nxt = upac_pkg::UPAC_ST_IDLE;
        end
      end
      upac_pkg::UPAC_ST_REMOVED: begin
        // Switches open, attach released, VBUS discharged, then Detect
        ctrl_nxt = '0;
        ctrl_nxt.discharge_on = 1'b1;
        attach_n_nxt = 1'b1;
        rem_nxt = 1'b1;
        dis_cnt_nxt = dis_cnt_r + 24'h000001;
        if (sense.vbus_discharged || (dis_cnt_r >= DISCHARGE_CYC)) begin
          dis_cnt_nxt = '0;
          ctrl_nxt.discharge_on = 1'b0;
          state_nxt = upac_pkg::UPAC_ST_DETECT;
        end
      end
      upac_pkg::UPAC_ST_IDLE: begin
        // Power withdrawn with device still attached
        ctrl_nxt = '0;
        ctrl_nxt.bypass_switch_on = 1'b1;
        if (removal_qualified) begin
          // Removal on the bypass path follows the same steps
          ctrl_nxt = '0;
          dis_cnt_nxt = '0;
          state_nxt = upac_pkg::UPAC_ST_REMOVED;
        end else if (port_power_enable && sense.main_supply_ok) begin
          ctrl_nxt.bypass_switch_on = 1'b0;
          mode_nxt = sel_mode;
          ctrl_nxt.discharge_on = needs_discharge(sel_mode);
          dis_cnt_nxt = '0;
          state_nxt = needs_discharge(sel_mode) ? upac_pkg::UPAC_ST_DISCHARGE : upac_pkg::UPAC_ST_ACTIVE;
        end
      end
      default: begin
        ctrl_nxt = '0;
        state_nxt = upac_pkg::UPAC_ST_DETECT;
      end
    endcase
    // CDP response counter is only ever cleared and never counts up to CDP_RESP_CYC; it does not end the answer
    if (ctrl_nxt.dm_drive_0p6 && cdp_cnt_r >= CDP_RESP_CYC) begin
      cdp_cnt_nxt = cdp_cnt_r;
    end
    // Attach flags set by hardware win over a clear
    if (state_r == upac_pkg::UPAC_ST_DETECT && attach_qualified && !removal_qualified) begin
      apin_nxt = 1'b1;
      att_nxt = 1'b1;
    end
    if (state_r == upac_pkg::UPAC_ST_REMOVED) begin
      rem_nxt = 1'b1;
    end
    // Never both power paths
    if (ctrl_nxt.main_switch_on) begin
      ctrl_nxt.bypass_switch_on = 1'b0;
    end
    // Detect flag registered together with the state it reports
    in_detect_nxt = (state_nxt == upac_pkg::UPAC_ST_DETECT);
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= upac_pkg::UPAC_ST_DETECT;
      mode_r <= upac_pkg::UPAC_MODE_PASS;
      ctrl_r <= '0;
      attach_n_r <= 1'b1;
      apin_r <= 1'b0;
      att_r <= 1'b0;
      rem_r <= 1'b0;
      dis_cnt_r <= '0;
      cdp_cnt_r <= '0;
      cdp_wait_up_r <= 1'b0;
      cdp_wait_dn_r <= 1'b0;
      in_detect_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      attach_n_r <= attach_n_nxt;
      apin_r <= apin_nxt;
      att_r <= att_nxt;
      rem_r <= rem_nxt;
      dis_cnt_r <= dis_cnt_nxt;
      cdp_cnt_r <= cdp_cnt_nxt;
      cdp_wait_up_r <= cdp_wait_up_nxt;
      cdp_wait_dn_r <= cdp_wait_dn_nxt;
      in_detect_r <= in_detect_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign ctrl = ctrl_r;
  assign attach_flag_n = attach_n_r;
  assign attach_pin_status = apin_r;
  assign attach_status = att_r;
  assign removal_status = rem_r;
  assign active_mode = mode_r;
  assign in_detect = in_detect_r;

endmodule

// File: bench/upac_port_ctrl_sva.sv
// Checker for the port attach and mode controller, bound to its top module.
// Assumes upac_pkg is compiled first and the clock and reset of the design.
`timescale 1ns/10ps
module upac_port_ctrl_sva #(
  parameter logic [23:0] ATTACH_QUAL_CYC = 24'h000008
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic detect_feature_enable,
  input wire upac_pkg::upac_sense_t sense,
  input wire upac_pkg::upac_ctrl_t ctrl,
  input wire logic attach_flag_n,
  input wire logic attach_pin_status,
  input wire logic attach_status,
  input wire logic removal_status,
  input wire upac_pkg::upac_mode_t active_mode,
  input wire logic in_detect
);
  logic [23:0] above_r;
  logic [23:0] above_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Counts consecutive cycles with load above the attach level
  always_comb begin
    above_nxt = sense.load_above_attach ? above_r + 24'h000001 : 24'h000000;
    if (!rstn) above_nxt = 24'h000000;
  end
  always_ff @(posedge clk) begin
    above_r <= above_nxt;
  end

  // Removal steps: switches open with flag released, then home in Detect
  sequence s_released;
    !ctrl.main_switch_on && !ctrl.bypass_switch_on && attach_flag_n;
  endsequence
  sequence s_home;
    in_detect && !ctrl.main_switch_on;
  endsequence

  AST_SWITCH_EXCL: assert property (!(ctrl.main_switch_on && ctrl.bypass_switch_on))
    else $error("main and bypass switch both on");
  AST_DETECT_HS: assert property (in_detect |-> !ctrl.hs_switch_closed)
    else $error("data switch closed in detect");
  AST_ATTACH_DETECT: assert property ($fell(attach_flag_n) |-> $past(in_detect))
    else $error("attach flagged outside detect");
  AST_ATTACH_TIME: assert property ($fell(attach_flag_n) |-> above_r > ATTACH_QUAL_CYC)
    else $error("attach flagged too early");
  AST_ATTACH_FLAGS: assert property ($fell(attach_flag_n) |-> ##[0:1] (attach_status && attach_pin_status))
    else $error("attach status bits not set");
  AST_REMOVAL_EN: assert property ($rose(removal_status) |-> $past(detect_feature_enable))
    else $error("removal while detection disabled");
  AST_REMOVAL_SEQ: assert property ($rose(removal_status) |-> s_released ##[1:60] s_home)
    else $error("removal sequence broken");
  AST_CDP_ANSWER: assert property (ctrl.cdp_profile && sense.dp_primary_level |-> ##[1:2] ctrl.dm_drive_0p6)
    else $error("no answer on data minus");
  AST_CDP_RELEASE: assert property (ctrl.dm_drive_0p6 && !sense.dp_high |-> ##[1:2] !ctrl.dm_drive_0p6)
    else $error("data minus not released");
  AST_CDP_LIMIT: assert property (ctrl.cdp_profile |-> ctrl.cc_limit && ctrl.hs_switch_closed)
    else $error("cdp limit or data switch wrong");
  AST_DCP_PROFILE: assert property (ctrl.dcp_short && active_mode == upac_pkg::UPAC_MODE_DCP |->
    ctrl.cc_limit && !ctrl.hs_switch_closed && !ctrl.em_timeout_en)
    else $error("dcp profile controls wrong");
endmodule

bind upac_port_ctrl upac_port_ctrl_sva #(.ATTACH_QUAL_CYC(ATTACH_QUAL_CYC)) u_upac_port_ctrl_sva (
  .clk(clk), .rstn(rstn), .detect_feature_enable(detect_feature_enable), .sense(sense), .ctrl(ctrl),
  .attach_flag_n(attach_flag_n), .attach_pin_status(attach_pin_status), .attach_status(attach_status),
  .removal_status(removal_status), .active_mode(active_mode), .in_detect(in_detect));

// File: bench/upac_dev_model.sv
// Model of a portable device on the port: load current and data-plus.
// Assumes the controller's switch controls; supply is always good.
`timescale 1ns/10ps
module upac_dev_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic attached,
  input wire logic cdp_go,
  input wire upac_pkg::upac_ctrl_t ctrl,
  output upac_pkg::upac_sense_t sense
);
  logic [3:0] dis_r;
  logic [3:0] dis_nxt;
  logic draw;

  // VBUS drains only after a few cycles of discharge
  always_comb begin
    dis_nxt = (dis_r == 4'hf) ? dis_r : dis_r + 4'h1;
    if (!rstn || !ctrl.discharge_on) dis_nxt = 4'h0;
  end
  always_ff @(posedge clk) begin
    dis_r <= dis_nxt;
  end

  // Load flows only while some switch feeds VBUS
  assign draw = attached && (ctrl.main_switch_on || ctrl.bypass_switch_on);
  always_comb begin
    sense.load_above_attach = draw;
    sense.load_below_removal = !draw;
    sense.main_supply_ok = 1'b1;
    sense.vbus_discharged = (dis_r >= 4'h3) && !ctrl.main_switch_on && !ctrl.bypass_switch_on;
    sense.dp_primary_level = cdp_go && ctrl.cdp_profile && ctrl.main_switch_on;
    sense.dp_high = sense.dp_primary_level;
  end
endmodule

// File: bench/upac_port_ctrl_tb.sv
// Self-checking bench for the port attach and mode controller.
// Assumes short qualification counts of 8 and the device model.
`timescale 1ns/10ps
module upac_port_ctrl_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic port_power_enable = 1'b0;
  logic detect_feature_enable = 1'b0;
  logic status_clear = 1'b0;
  logic attached = 1'b0;
  logic cdp_go = 1'b0;
  logic seen = 1'b0;
  upac_pkg::upac_sel_t sel = 3'h6;
  upac_pkg::upac_sense_t sense;
  upac_pkg::upac_ctrl_t ctrl;
  upac_pkg::upac_mode_t active_mode;
  logic attach_flag_n, attach_pin_status, attach_status, removal_status, in_detect;
  int fails = 0;
  int total_checks = 0;
  logic [2:0] codes [7] = '{3'h4, 3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2};
  upac_pkg::upac_mode_t modes [7] = '{upac_pkg::UPAC_MODE_SDP, upac_pkg::UPAC_MODE_CDP, upac_pkg::UPAC_MODE_DCP,
    upac_pkg::UPAC_MODE_DCE, upac_pkg::UPAC_MODE_DCE, upac_pkg::UPAC_MODE_PASS, upac_pkg::UPAC_MODE_PASS};

  always #50 clk = ~clk;

  upac_port_ctrl #(.ATTACH_QUAL_CYC(24'h000008), .REMOVAL_QUAL_CYC(24'h000008), .DISCHARGE_CYC(24'h000008),
    .CDP_RESP_CYC(24'h000008)) u_upac_port_ctrl (.clk(clk), .rstn(rstn), .port_power_enable(port_power_enable),
    .detect_feature_enable(detect_feature_enable), .sel(sel), .sense(sense), .status_clear(status_clear),
    .ctrl(ctrl), .attach_flag_n(attach_flag_n), .attach_pin_status(attach_pin_status),
    .attach_status(attach_status), .removal_status(removal_status), .active_mode(active_mode),
    .in_detect(in_detect));

  upac_dev_model u_upac_dev_model (.clk(clk), .rstn(rstn), .attached(attached), .cdp_go(cdp_go), .ctrl(ctrl),
    .sense(sense));

  // Compare and count
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Step n cycles, noting any discharge on the way
  task tk(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (ctrl.discharge_on === 1'b1) seen = 1'b1;
    end
  endtask

  // Bounded wait: 0 attach flag, 1 detect, 2 main switch
  task automatic wt(input int k, input logic v);
    int n;
    logic c;
    for (n = 0; n < 80; n++) begin
      c = (k == 0) ? attach_flag_n : (k == 1) ? in_detect : ctrl.main_switch_on;
      if (c === v) break;
      tk(1);
    end
    chk(n < 80, 1'b1);
  endtask

  task summarize;
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    tk(2);
    chk(ctrl, 9'h000);
    chk({attach_status, attach_pin_status, removal_status, attach_flag_n, in_detect}, 5'h03);
    @(posedge clk) rstn <= 1'b1;
    tk(2);
    chk({ctrl.bypass_switch_on, ctrl.main_switch_on}, 2'h2);
    @(posedge clk) attached <= 1'b1;
    tk(4);
    @(posedge clk) attached <= 1'b0;
    tk(12);
    chk(attach_flag_n, 1'b1);
    @(posedge clk) attached <= 1'b1;
    wt(0, 1'b0);
    tk(10);
    chk({attach_status, attach_pin_status, ctrl.main_switch_on, ctrl.hs_switch_closed}, 4'hc);
    seen = 1'b0;
    @(posedge clk) port_power_enable <= 1'b1;
    wt(2, 1'b1);
    chk({seen, active_mode, ctrl.hs_switch_closed, ctrl.cc_limit}, 5'h02);
    for (int i = 0; i < 7; i++) begin
      seen = 1'b0;
      @(posedge clk) sel <= codes[i];
      if (i < 4) begin
        wt(2, 1'b0);
        wt(2, 1'b1);
      end else tk(6);
      chk(seen, i < 4);
      chk(active_mode, modes[i]);
      case (modes[i])
        upac_pkg::UPAC_MODE_SDP: chk({ctrl.hs_switch_closed, ctrl.cc_limit}, 2'h2);
        upac_pkg::UPAC_MODE_PASS: chk({ctrl.hs_switch_closed, ctrl.cc_limit}, 2'h2);
        upac_pkg::UPAC_MODE_DCP: begin
          chk({ctrl.hs_switch_closed, ctrl.cc_limit, ctrl.dcp_short, ctrl.em_timeout_en}, 4'h6);
          @(posedge clk) port_power_enable <= 1'b0;
          tk(4);
          chk({ctrl.main_switch_on, ctrl.bypass_switch_on, active_mode}, 5'h0a);
          @(posedge clk) port_power_enable <= 1'b1;
          wt(2, 1'b1);
          chk({ctrl.dcp_short, ctrl.em_timeout_en}, 2'h2);
        end
        upac_pkg::UPAC_MODE_DCE: chk({ctrl.dcp_short, ctrl.cc_limit, ctrl.em_timeout_en, ctrl.hs_switch_closed},
          4'he);
        upac_pkg::UPAC_MODE_CDP: begin
          chk({ctrl.hs_switch_closed, ctrl.cc_limit, ctrl.cdp_profile}, 3'h7);
          @(posedge clk) cdp_go <= 1'b1;
          tk(3);
          chk(ctrl.dm_drive_0p6, 1'b1);
          @(posedge clk) cdp_go <= 1'b0;
          tk(3);
          chk(ctrl.dm_drive_0p6, 1'b0);
        end
        default: ;
      endcase
    end
    @(posedge clk) port_power_enable <= 1'b0;
    tk(6);
    chk({active_mode, ctrl.main_switch_on}, 4'h1);
    @(posedge clk) port_power_enable <= 1'b1;
    @(posedge clk) attached <= 1'b0;
    tk(30);
    chk({removal_status, attach_flag_n}, 2'h0);
    seen = 1'b0;
    @(posedge clk) detect_feature_enable <= 1'b1;
    wt(1, 1'b1);
    chk({removal_status, attach_flag_n, ctrl.main_switch_on, seen}, 4'hd);
    tk(5);
    chk({in_detect, ctrl.main_switch_on}, 2'h2);
    @(posedge clk) status_clear <= 1'b1;
    @(posedge clk) status_clear <= 1'b0;
    tk(1);
    chk({removal_status, attach_status, attach_pin_status}, 3'h0);
    summarize;
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule
